// ### pci_host_port_map.vh
// Constants for the PCI agent host port: register offsets, field positions,
// mode codes, host pin layout and FIFO sizes.
// Assumes it is included by bare name from the design files.
`ifndef PCI_HOST_PORT_MAP_VH
`define PCI_HOST_PORT_MAP_VH

// APB register byte offsets.
`define APB_ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_SLAVE_TX 8'h08
`define OFF_MASTER_TX 8'h0C
`define OFF_RX 8'h10
`define OFF_SUBSYS 8'h14
`define OFF_CFG_RES 8'h18

// Control register fields.
`define CTRL_MODE_MSB 2
`define CTRL_MODE_LSB 0
`define CTRL_HTF 3
`define CTRL_GRST 4

// Host port mode codes.
`define MODE_W 3
`define MODE_NONE 3'h0
`define MODE_PCI 3'h1
`define MODE_SELF 3'h5

// Host transfer format: zero selects 32-bit packing of two half words.
`define HTF_32BIT 1'h0
`define HALF_W 16

// Core status register bits.
`define STAT_W 8
`define STAT_SLAVE_TX 0
`define STAT_SLAVE_RX 1
`define STAT_MASTER_TX 2
`define STAT_MASTER_RX 3
`define STAT_HOST_TX_EMPTY 4
`define STAT_HOST_TX_REQ 5
`define STAT_HOST_RX_REQ 6
`define STAT_ACTIVE 7

// Host side status bits, returned on a host status read.
`define HSTAT_W 3

// Host pin address codes.
`define HA_STATUS 2'h0
`define HA_SLAVE 2'h1
`define HA_MASTER 2'h2
`define HA_SPARE 2'h3
// Host configuration addresses.
`define CA_SUBSYS 2'h0
`define CA_RES 2'h1

// Layout of the synchronised host pin vector.
`define PIN_DATA_MSB 31
`define PIN_DATA_LSB 0
`define PIN_ADDR_MSB 33
`define PIN_ADDR_LSB 32
`define PIN_WR 34
`define PIN_CFG 35
`define PIN_REQ 36
`define PIN_CLK 37
`define PIN_HOST_SIDE_RESET_N 38
`define PIN_W 39

// FIFO sizes.
`define DATA_W 32
`define RX_W 33
`define RX_TAG 32
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ### port_fifo.v
// Synchronous flip-flop FIFO used for each data path of the host port.
// Assumes one clock; clear empties it without touching stored words.
`timescale 1ns/1ps
`default_nettype none
`include "pci_host_port_map.vh"

module port_fifo #(
	parameter W = `DATA_W
) (
	input wire clock,
	input wire rst,
	input wire clear,
	input wire push,
	input wire [W-1:0] wdata,
	input wire pop,
	output wire [W-1:0] rdata,
	output wire full,
	output wire empty
);
	reg [W-1:0] mem [0:`FIFO_DEPTH-1];
	reg [`FIFO_AW-1:0] wr_idx;
	reg [`FIFO_AW-1:0] rd_idx;
	reg [`FIFO_AW:0] count;
	wire do_push;
	wire do_pop;

	assign full = (count == `FIFO_DEPTH);
	assign empty = (count == {(`FIFO_AW+1){1'b0}});
	assign rdata = mem[rd_idx];
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;

	always @(posedge clock)
	begin
		if (do_push)
			mem[wr_idx] <= wdata;
	end

	always @(posedge clock)
	begin
		if (rst || clear)
		begin
			wr_idx <= {`FIFO_AW{1'b0}};
			rd_idx <= {`FIFO_AW{1'b0}};
			count <= {(`FIFO_AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_idx <= wr_idx + 1'b1;
			if (do_pop)
				rd_idx <= rd_idx + 1'b1;
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end
endmodule // port_fifo

`default_nettype wire

// ### pci_host_port.v
// PCI agent host port: APB slave towards the core, sampled host pins towards the PCI host.
// Assumes host pins are asynchronous to clock; the host holds a request until it sees ack or retry.
`timescale 1ns/1ps
`default_nettype none
`include "pci_host_port_map.vh"

module pci_host_port (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`APB_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire host_side_reset_n,
	input wire host_clk,
	input wire host_req,
	input wire host_cfg,
	input wire host_wr,
	input wire [1:0] host_addr,
	input wire [31:0] host_wdata,
	output reg [31:0] host_rdata,
	output reg host_ack,
	output reg host_retry,
	output reg host_oe
);
	localparam S_IDLE = 3'b001;
	localparam S_WAIT = 3'b010;
	localparam S_DONE = 3'b100;

	reg [`PIN_W-1:0] sync1;
	reg [`PIN_W-1:0] sync2;
	reg [`PIN_W-1:0] sync3;
	reg [`PIN_W-1:0] pins;
	reg clk_prev;
	reg [2:0] state;
	reg [`MODE_W-1:0] host_port_mode_field;
	reg host_transfer_format;
	reg gen_pending;
	reg [31:0] subsys_id;
	reg [31:0] cfg_res;
	reg slave_half;
	reg master_half;
	reg rx_half;
	reg [`HALF_W-1:0] slave_low;
	reg [`HALF_W-1:0] master_low;
	reg [`STAT_W-1:0] stat_d1;
	reg [`STAT_W-1:0] stat_d2;
	reg [31:0] next_prdata;
	reg mapped;
	reg data_ready;

	wire [31:0] pin_data;
	wire [1:0] pin_addr;
	wire pin_wr;
	wire pin_cfg;
	wire pin_req;
	wire host_rst_ok;
	wire pci_edge;
	wire pci_mode;
	wire fmt32;
	wire start_ok;
	wire host_go;
	wire host_go_cfg;
	wire gen_fire;
	wire apb_acc;
	wire wr_acc;
	wire rd_acc;
	wire [`MODE_W-1:0] wr_mode;
	wire [`DATA_W-1:0] s_rdata;
	wire [`DATA_W-1:0] m_rdata;
	wire [`RX_W-1:0] rx_rdata;
	wire s_full, s_empty, m_full, m_empty, rx_full, rx_empty;
	wire s_push, m_push, rx_push, s_pop, m_pop, rx_pop;
	wire [`DATA_W-1:0] s_wdata;
	wire [`DATA_W-1:0] m_wdata;
	wire slave_tx_request_flag;
	wire slave_rx_request_flag;
	wire master_tx_request_flag;
	wire master_rx_request_flag;
	wire host_tx_empty_flag;
	wire host_tx_request_flag;
	wire host_rx_request_flag;
	wire [`STAT_W-1:0] stat_now;
	wire [`HSTAT_W-1:0] host_side_status_reg;

	// Each host pin passes three flops; a new level is taken only when the last two agree.
	always @(posedge clock)
	begin
		if (rst)
		begin
			sync1 <= {`PIN_W{1'b0}};
			sync2 <= {`PIN_W{1'b0}};
			sync3 <= {`PIN_W{1'b0}};
			pins <= {`PIN_W{1'b0}};
			clk_prev <= 1'b0;
		end
		else
		begin
			sync1 <= {host_side_reset_n, host_clk, host_req, host_cfg, host_wr, host_addr, host_wdata};
			sync2 <= sync1;
			sync3 <= sync2;
			pins <= (sync2 & sync3) | (pins & (sync2 ^ sync3));
			clk_prev <= pins[`PIN_CLK];
		end
	end

	assign pin_data = pins[`PIN_DATA_MSB:`PIN_DATA_LSB];
	assign pin_addr = pins[`PIN_ADDR_MSB:`PIN_ADDR_LSB];
	assign pin_wr = pins[`PIN_WR];
	assign pin_cfg = pins[`PIN_CFG];
	assign pin_req = pins[`PIN_REQ];
	assign host_rst_ok = pins[`PIN_HOST_SIDE_RESET_N];
	assign pci_edge = pins[`PIN_CLK] & ~clk_prev;
	assign pci_mode = (host_port_mode_field == `MODE_PCI);
	assign fmt32 = (host_transfer_format == `HTF_32BIT);

	// A FIFO that cannot serve the access holds the host in wait states.
	always @*
	begin
		data_ready = 1'b1;
		case (pin_addr)
			`HA_SLAVE: data_ready = pin_wr ? ~rx_full : ~s_empty;
			`HA_MASTER: data_ready = pin_wr ? ~rx_full : ~m_empty;
			default: data_ready = 1'b1;
		endcase
	end

	// No new transaction starts while a general reset waits for the bus to go idle.
	assign start_ok = pci_edge & host_rst_ok & pin_req & (state == S_IDLE) & ~gen_pending;
	assign host_go_cfg = start_ok & pci_mode & pin_cfg;
	assign host_go = pci_edge & host_rst_ok & pin_req & data_ready
		& ((start_ok & pci_mode & ~pin_cfg) | (state == S_WAIT));

	// The shared inbound FIFO accepts any slave or master write while not full, so an empty FIFO takes
	// a full burst of eight words, covering both no-wait bursts.
	assign rx_push = host_go & pin_wr & (pin_addr == `HA_SLAVE || pin_addr == `HA_MASTER);
	assign s_pop = host_go & ~pin_wr & (pin_addr == `HA_SLAVE);
	assign m_pop = host_go & ~pin_wr & (pin_addr == `HA_MASTER);

	assign host_tx_empty_flag = rx_empty;
	assign host_tx_request_flag = ~rx_full;
	assign host_rx_request_flag = ~s_empty;
	assign host_side_status_reg = {host_rx_request_flag, host_tx_request_flag, host_tx_empty_flag};

	// Host transaction engine; host reset idles it and floats the outputs.
	always @(posedge clock)
	begin
		if (rst || !host_rst_ok)
		begin
			state <= S_IDLE;
			host_ack <= 1'b0;
			host_retry <= 1'b0;
			host_oe <= 1'b0;
			host_rdata <= 32'h00000000;
		end
		else if (pci_edge)
		begin
			case (state)
				S_IDLE:
				begin
					if (pin_req && !gen_pending)
					begin
						if (!pci_mode)
						begin
							host_retry <= 1'b1;
							host_oe <= 1'b1;
							state <= S_DONE;
						end
						else if (pin_cfg)
						begin
							host_ack <= 1'b1;
							host_oe <= 1'b1;
							host_rdata <= (pin_addr == `CA_SUBSYS) ? subsys_id :
								(pin_addr == `CA_RES) ? cfg_res : 32'h00000000;
							state <= S_DONE;
						end
						else if (data_ready)
						begin
							host_ack <= 1'b1;
							host_oe <= 1'b1;
							host_rdata <= (pin_addr == `HA_SLAVE) ? s_rdata :
								(pin_addr == `HA_MASTER) ? m_rdata :
								{{(32-`HSTAT_W){1'b0}}, host_side_status_reg};
							state <= S_DONE;
						end
						else
							state <= S_WAIT;
					end
				end
				S_WAIT:
				begin
					if (!pin_req)
						state <= S_IDLE;
					else if (data_ready)
					begin
						host_ack <= 1'b1;
						host_oe <= 1'b1;
						host_rdata <= (pin_addr == `HA_SLAVE) ? s_rdata : m_rdata;
						state <= S_DONE;
					end
				end
				S_DONE:
				begin
					if (!pin_req)
					begin
						host_ack <= 1'b0;
						host_retry <= 1'b0;
						host_oe <= 1'b0;
						state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// APB side: pready rises one cycle into the access phase.
	assign apb_acc = psel & penable & pready;
	assign wr_acc = apb_acc & pwrite;
	assign rd_acc = apb_acc & ~pwrite;
	assign wr_mode = pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	assign gen_fire = gen_pending & (state == S_IDLE);

	// Control register and the general reset sequence.
	always @(posedge clock)
	begin
		if (rst)
		begin
			host_port_mode_field <= `MODE_NONE;
			host_transfer_format <= `HTF_32BIT;
			gen_pending <= 1'b0;
		end
		else if (gen_fire)
		begin
			host_port_mode_field <= `MODE_NONE;
			// A general reset written in the cycle in which the pending one fires stays pending.
			gen_pending <= wr_acc && paddr == `OFF_CTRL && pwdata[`CTRL_GRST];
		end
		else if (wr_acc && paddr == `OFF_CTRL)
		begin
			host_port_mode_field <= wr_mode;
			host_transfer_format <= pwdata[`CTRL_HTF];
			gen_pending <= gen_pending | pwdata[`CTRL_GRST];
		end
	end

	// Configuration registers: cleared by host reset, never by the general reset.
	always @(posedge clock)
	begin
		if (rst || !host_rst_ok)
		begin
			subsys_id <= 32'h00000000;
			cfg_res <= 32'h00000000;
		end
		else
		begin
			if (wr_acc && paddr == `OFF_SUBSYS
				&& (host_port_mode_field == `MODE_SELF || pci_mode))
				subsys_id <= pwdata;
			if (host_go_cfg && pin_wr && pin_addr == `CA_RES)
				cfg_res <= pin_data;
		end
	end

	// In 32-bit format the core writes the low half first, then the high half.
	assign s_push = wr_acc & (paddr == `OFF_SLAVE_TX) & ~s_full & (~fmt32 | slave_half);
	assign m_push = wr_acc & (paddr == `OFF_MASTER_TX) & ~m_full & (~fmt32 | master_half);
	assign s_wdata = fmt32 ? {pwdata[`HALF_W-1:0], slave_low} : pwdata;
	assign m_wdata = fmt32 ? {pwdata[`HALF_W-1:0], master_low} : pwdata;
	assign rx_pop = rd_acc & (paddr == `OFF_RX) & ~rx_empty & (~fmt32 | rx_half);

	// Half-word phases; host reset leaves them, general reset clears them.
	always @(posedge clock)
	begin
		if (rst || gen_fire)
		begin
			slave_half <= 1'b0;
			master_half <= 1'b0;
			rx_half <= 1'b0;
			slave_low <= {`HALF_W{1'b0}};
			master_low <= {`HALF_W{1'b0}};
		end
		else if (fmt32)
		begin
			if (wr_acc && paddr == `OFF_SLAVE_TX && !s_full)
			begin
				slave_half <= ~slave_half;
				if (!slave_half)
					slave_low <= pwdata[`HALF_W-1:0];
			end
			if (wr_acc && paddr == `OFF_MASTER_TX && !m_full)
			begin
				master_half <= ~master_half;
				if (!master_half)
					master_low <= pwdata[`HALF_W-1:0];
			end
			if (rd_acc && paddr == `OFF_RX && !rx_empty)
				rx_half <= ~rx_half;
		end
	end

	port_fifo #(.W(`DATA_W)) slave_out_fifo (
		.clock(clock),
		.rst(rst),
		.clear(gen_fire),
		.push(s_push),
		.wdata(s_wdata),
		.pop(s_pop),
		.rdata(s_rdata),
		.full(s_full),
		.empty(s_empty)
	);

	port_fifo #(.W(`DATA_W)) master_out_fifo (
		.clock(clock),
		.rst(rst),
		.clear(gen_fire),
		.push(m_push),
		.wdata(m_wdata),
		.pop(m_pop),
		.rdata(m_rdata),
		.full(m_full),
		.empty(m_empty)
	);

	port_fifo #(.W(`RX_W)) shared_in_fifo (
		.clock(clock),
		.rst(rst),
		.clear(gen_fire),
		.push(rx_push),
		.wdata({pin_addr == `HA_MASTER, pin_data}),
		.pop(rx_pop),
		.rdata(rx_rdata),
		.full(rx_full),
		.empty(rx_empty)
	);

	assign slave_tx_request_flag = ~s_full;
	assign master_tx_request_flag = ~m_full;
	assign slave_rx_request_flag = ~rx_empty & ~rx_rdata[`RX_TAG];
	assign master_rx_request_flag = ~rx_empty & rx_rdata[`RX_TAG];
	assign stat_now = {state != S_IDLE, host_rx_request_flag, host_tx_request_flag, host_tx_empty_flag,
		master_rx_request_flag, master_tx_request_flag, slave_rx_request_flag, slave_tx_request_flag};

	// Status seen by the core trails the FIFOs by two cycles.
	always @(posedge clock)
	begin
		if (rst)
		begin
			stat_d1 <= {`STAT_W{1'b0}};
			stat_d2 <= {`STAT_W{1'b0}};
		end
		else
		begin
			stat_d1 <= stat_now;
			stat_d2 <= stat_d1;
		end
	end

	// Read multiplexer; unmapped offsets answer with an error and zero data.
	always @*
	begin
		next_prdata = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`OFF_CTRL: next_prdata = {{(31-`CTRL_HTF){1'b0}}, host_transfer_format, host_port_mode_field};
			`OFF_STATUS: next_prdata = {{(32-`STAT_W){1'b0}}, stat_d2};
			`OFF_SLAVE_TX: next_prdata = 32'h00000000;
			`OFF_MASTER_TX: next_prdata = 32'h00000000;
			`OFF_RX:
			begin
				if (rx_empty)
					next_prdata = 32'h00000000;
				else if (!fmt32)
					next_prdata = rx_rdata[`DATA_W-1:0];
				else if (rx_half)
					next_prdata = {{`HALF_W{1'b0}}, rx_rdata[`DATA_W-1:`HALF_W]};
				else
					next_prdata = {{`HALF_W{1'b0}}, rx_rdata[`HALF_W-1:0]};
			end
			`OFF_SUBSYS: next_prdata = subsys_id;
			`OFF_CFG_RES: next_prdata = cfg_res;
			default: mapped = 1'b0;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (psel && penable && !pready)
		begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // pci_host_port

`default_nettype wire

// ### pci_host_port_chk.sv
// Concurrent checks on the ports of the PCI agent host port.
// Assumes binding to pci_host_port; one clock domain with synchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
`include "pci_host_port_map.vh"

module pci_host_port_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic host_side_reset_n,
	input wire logic host_clk,
	input wire logic host_req,
	input wire logic host_cfg,
	input wire logic host_wr,
	input wire logic [1:0] host_addr,
	input wire logic [31:0] host_wdata,
	input wire logic [31:0] host_rdata,
	input wire logic host_ack,
	input wire logic host_retry,
	input wire logic host_oe
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	apb_answer_a: assert property (psel && !penable |-> ##2 pready)
		else $error("APB answer not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0 |->
		pslverr == (paddr > `OFF_CFG_RES) && (!pslverr || prdata == 32'h0))
		else $error("error response does not match the offset");
	ack_retry_excl_a: assert property (!(host_ack && host_retry))
		else $error("ack and retry together");
	drive_enable_a: assert property (host_ack || host_retry |-> host_oe)
		else $error("answer given with outputs floating");
	host_reset_float_a: assert property (!host_side_reset_n [*6] |-> !host_oe && !host_ack && !host_retry)
		else $error("host outputs driven under host reset");
	ack_holds_a: assert property ((host_ack && host_req && host_side_reset_n) [*6] |=> host_ack)
		else $error("ack dropped while request held");
	ack_cause_a: assert property ($rose(host_ack) || $rose(host_retry) |-> host_req && $past(host_req, 3))
		else $error("answer without a request");
	ack_release_a: assert property ($fell(host_ack) || $fell(host_retry) |-> !host_req || !host_side_reset_n)
		else $error("answer withdrawn while request held");
endmodule // pci_host_port_chk

bind pci_host_port pci_host_port_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.host_side_reset_n(host_side_reset_n), .host_clk(host_clk), .host_req(host_req), .host_cfg(host_cfg),
	.host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.host_ack(host_ack), .host_retry(host_retry), .host_oe(host_oe));
`default_nettype wire

// ### pci_host_model.sv
// Model of the PCI host and configurator facing the host port.
// Assumes the port holds ack or retry until a host clock edge sees the request dropped.
`timescale 1ns/1ps
`default_nettype none

module pci_host_model (
	output logic host_side_reset_n,
	output logic host_clk,
	output logic host_req,
	output logic host_cfg,
	output logic host_wr,
	output logic [1:0] host_addr,
	output logic [31:0] host_wdata,
	input wire logic [31:0] host_rdata,
	input wire logic host_ack,
	input wire logic host_retry,
	input wire logic host_oe
);
	initial
	begin
		host_side_reset_n = 1'b1;
		host_clk = 1'b0;
		host_req = 1'b0;
		host_cfg = 1'b0;
		host_wr = 1'b0;
		host_addr = 2'h0;
		host_wdata = 32'h0;
	end

	// The host clock runs only inside a transaction; released lines show the inverse.
	task automatic xfer(input logic cfg, input logic wr, input logic [1:0] addr, input logic [31:0] wd,
		input int limit, output logic [31:0] rd, output logic acked, output int periods);
		begin
			periods = 0;
			#13;
			host_cfg = cfg;
			host_wr = wr;
			host_addr = addr;
			host_wdata = wd;
			host_req = 1'b1;
			do
			begin
				#40 host_clk = 1'b1;
				#40 host_clk = 1'b0;
				periods++;
			end
			while (host_ack !== 1'b1 && host_retry !== 1'b1 && periods < limit);
			rd = host_oe ? host_rdata : 32'h0;
			acked = host_ack;
			host_req = 1'b0;
			host_cfg = ~cfg;
			host_wr = ~wr;
			host_addr = ~addr;
			host_wdata = ~wd;
			#40 host_clk = 1'b1;
			#40 host_clk = 1'b0;
		end
	endtask

	task automatic pulse_reset(input int ns);
		begin
			host_side_reset_n = 1'b0;
			#(ns) host_side_reset_n = 1'b1;
		end
	endtask
endmodule // pci_host_model
`default_nettype wire

// ### tb_pci_agent_host_port_dataflow.sv
// Self-checking bench for the PCI agent host port: APB master, host model, checker by bind.
// Assumes the host port map header and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "pci_host_port_map.vh"

module tb_pci_agent_host_port_dataflow;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, ard, rd;
	logic [31:0] w [0:7];
	logic aerr, ak;
	int per, i, checks = 0, miscompares = 0;
	wire logic [31:0] prdata, host_rdata, host_wdata;
	wire logic [1:0] host_addr;
	wire logic pready, pslverr, host_side_reset_n, host_clk, host_req, host_cfg, host_wr;
	wire logic host_ack, host_retry, host_oe;

	pci_host_port dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_side_reset_n(host_side_reset_n), .host_clk(host_clk), .host_req(host_req), .host_cfg(host_cfg),
		.host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_ack(host_ack), .host_retry(host_retry), .host_oe(host_oe));
	pci_host_model host (.host_side_reset_n(host_side_reset_n), .host_clk(host_clk), .host_req(host_req),
		.host_cfg(host_cfg), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .host_ack(host_ack), .host_retry(host_retry), .host_oe(host_oe));

	always #2.5 clock = ~clock;

	task print_verdict;
		begin
			if (miscompares == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks++;
			if (got !== exp)
			begin
				miscompares++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			do
				@(posedge clock);
			while (pready !== 1'b1);
			ard = prdata;
			aerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clock);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		begin
			apb(1'b0, a, 32'h0);
			chk(ard & mask, exp & mask);
		end
	endtask

	task automatic hx(input logic cfg, input logic wr, input logic [1:0] a, input logic [31:0] d);
		begin
			host.xfer(cfg, wr, a, d, 40, rd, ak, per);
			@(posedge clock);
		end
	endtask

	function automatic logic [31:0] exp_status(input int rx_n, input logic m_head, input int stx_n, input int mtx_n);
		begin
			exp_status = 32'h0;
			exp_status[`STAT_SLAVE_TX] = stx_n < `FIFO_DEPTH;
			exp_status[`STAT_SLAVE_RX] = rx_n > 0 && !m_head;
			exp_status[`STAT_MASTER_TX] = mtx_n < `FIFO_DEPTH;
			exp_status[`STAT_MASTER_RX] = rx_n > 0 && m_head;
			exp_status[`STAT_HOST_TX_EMPTY] = rx_n == 0;
			exp_status[`STAT_HOST_TX_REQ] = rx_n < `FIFO_DEPTH;
			exp_status[`STAT_HOST_RX_REQ] = stx_n > 0;
		end
	endfunction

	initial
	begin
		#200000;
		miscompares++;
		print_verdict;
	end

	initial
	begin
		void'($urandom(65));
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd_chk(`OFF_CTRL, 32'h0, ALL);
		rd_chk(`OFF_STATUS, exp_status(0, 1'b0, 0, 0), 32'hFF);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, aerr}, 32'h1);
		for (i = 0; i < 8; i++)
		begin
			w[0] = $urandom;
			wr(`OFF_CTRL, 32'h8 | i);
			hx(1'b0, 1'b1, `HA_SLAVE, w[0]);
			chk({31'h0, ak}, i == 1);
			chk(per, 32'h1);
			rd_chk(`OFF_STATUS, exp_status(i == 1, 1'b0, 0, 0), 32'hFF);
			if (i == 1)
				rd_chk(`OFF_RX, w[0], ALL);
		end
		w[0] = $urandom;
		w[1] = $urandom;
		wr(`OFF_CTRL, {29'h0, `MODE_SELF});
		wr(`OFF_SUBSYS, w[0]);
		hx(1'b1, 1'b0, `CA_SUBSYS, 32'h0);
		chk({31'h0, ak}, 32'h0);
		chk(per, 32'h1);
		wr(`OFF_CTRL, {29'h0, `MODE_PCI});
		hx(1'b1, 1'b0, `CA_SUBSYS, 32'h0);
		chk(rd, w[0]);
		hx(1'b1, 1'b1, `CA_RES, w[1]);
		rd_chk(`OFF_CFG_RES, w[1], ALL);
		wr(`OFF_CTRL, 32'h9);
		for (i = 0; i < 6; i++)
		begin
			w[i] = $urandom;
			hx(1'b0, 1'b1, i < 3 ? `HA_SLAVE : `HA_MASTER, w[i]);
			chk(per, 32'h1);
		end
		rd_chk(`OFF_STATUS, exp_status(6, 1'b0, 0, 0), 32'hFF);
		for (i = 0; i < 6; i++)
		begin
			if (i == 3)
				rd_chk(`OFF_STATUS, exp_status(3, 1'b1, 0, 0), 32'hFF);
			rd_chk(`OFF_RX, w[i], ALL);
		end
		rd_chk(`OFF_STATUS, exp_status(0, 1'b0, 0, 0), 32'hFF);
		wr(`OFF_CTRL, {29'h0, `MODE_PCI});
		for (i = 0; i < 3; i++)
		begin
			w[i] = $urandom;
			hx(1'b0, 1'b1, `HA_SLAVE, w[i]);
			chk(per, 32'h1);
		end
		for (i = 0; i < 6; i++)
			rd_chk(`OFF_RX, i[0] ? w[i / 2][31:16] : w[i / 2][15:0], 32'hFFFF);
		wr(`OFF_CTRL, 32'h9);
		for (i = 0; i < 8; i++)
		begin
			w[i] = $urandom;
			wr(`OFF_SLAVE_TX, w[i]);
			wr(`OFF_MASTER_TX, ~w[i]);
		end
		rd_chk(`OFF_STATUS, exp_status(0, 1'b0, 8, 8), 32'hFF);
		hx(1'b0, 1'b0, `HA_STATUS, 32'h0);
		chk(rd, 32'h7);
		host.pulse_reset(100);
		repeat (10) @(posedge clock);
		rd_chk(`OFF_SUBSYS, 32'h0, ALL);
		rd_chk(`OFF_CFG_RES, 32'h0, ALL);
		rd_chk(`OFF_STATUS, exp_status(0, 1'b0, 8, 8), 32'hFF);
		for (i = 0; i < 8; i++)
		begin
			hx(1'b0, 1'b0, `HA_SLAVE, 32'h0);
			chk(rd, w[i]);
			hx(1'b0, 1'b0, `HA_MASTER, 32'h0);
			chk(rd, ~w[i]);
		end
		w[0] = $urandom;
		fork
			hx(1'b0, 1'b0, `HA_MASTER, 32'h0);
			begin
				repeat (60) @(posedge clock);
				wr(`OFF_MASTER_TX, w[0]);
			end
		join
		chk(rd, w[0]);
		chk(per > 2, 32'h1);
		w[1] = $urandom;
		w[3] = $urandom;
		wr(`OFF_SLAVE_TX, w[1]);
		hx(1'b0, 1'b1, `HA_MASTER, w[1]);
		hx(1'b1, 1'b1, `CA_RES, w[3]);
		wr(`OFF_CTRL, 32'h19);
		repeat (8) @(posedge clock);
		rd_chk(`OFF_CTRL, 32'h0, 32'h7);
		rd_chk(`OFF_STATUS, exp_status(0, 1'b0, 0, 0), 32'hFF);
		rd_chk(`OFF_CFG_RES, w[3], ALL);
		hx(1'b0, 1'b1, `HA_SLAVE, w[1]);
		chk({31'h0, ak}, 32'h0);
		chk(per, 32'h1);
		print_verdict;
	end
endmodule // tb_pci_agent_host_port_dataflow
`default_nettype wire
